// ==== dv/sof_host_model.sv ====
// Purpose : Host controller and converter stand-in for the filter control block
// Assumes : Every strobe is raised 1 ns after a rising edge and held one cycle
// Notes   : Released lines show the inverse of their last value, so stale data never matches
`timescale 1ns/100ps
module sof_host_model (
    input  wire logic               clk,
    output logic                    spiMode,
    output logic                    regWrite,
    output logic                    regRead,
    output sof_pkg::sof_byte_t      regAddr,
    output sof_pkg::sof_byte_t      regWrData,
    input  wire sof_pkg::sof_byte_t regRdData,
    input  wire logic               regRdValid,
    output logic                    convDone,
    output sof_pkg::sof_res_t       adcTemp,
    output sof_pkg::sof_res_t       adcPress,
    output sof_pkg::sof_hum_t       adcHum
);
    import sof_pkg::*;
    initial begin
        {spiMode, regWrite, regRead, convDone} = 4'h0;
        {regAddr, regWrData} = 16'h0000;
        {adcTemp, adcPress, adcHum} = 56'h0;
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic setMode(input logic m);
        @(posedge clk);
        #1 spiMode = m;
    endtask
    task automatic writeReg(input sof_byte_t a, input sof_byte_t d);
        @(posedge clk);
        #1 {regWrite, regAddr, regWrData} = {1'b1, a, d};
        @(posedge clk);
        #1 {regWrite, regAddr, regWrData} = {1'b0, ~a, ~d};
    endtask
    task automatic readReg(input sof_byte_t a, output sof_byte_t d, output logic v);
        @(posedge clk);
        #1 {regRead, regAddr} = {1'b1, a};
        @(posedge clk);
        #1 {regRead, regAddr} = {1'b0, ~a};
        v = regRdValid;
        d = regRdData;
    endtask
    task automatic selectPage(input logic pg);
        writeReg(8'h73, {3'h0, pg, 4'h0});
    endtask
    task automatic measure(input sof_res_t t, input sof_res_t p, input sof_hum_t h);
        @(posedge clk);
        #1 {convDone, adcTemp, adcPress, adcHum} = {1'b1, t, p, h};
        @(posedge clk);
        #1 {convDone, adcTemp, adcPress, adcHum} = {1'b0, ~t, ~p, ~h};
    endtask
endmodule

// ==== dv/testbench.sv ====
// Purpose : Self-checking bench for the oversampling and IIR filter control block
// Assumes : I2C addressing unless a scenario switches to SPI pages
// Notes   : Filter expectations come from a reference step kept in the bench
`timescale 1ns/100ps
`include "sof_defs.svh"
module testbench;
    import sof_pkg::*;
    localparam sof_byte_t ID = 8'h3c; // Arbitrary value
    logic               clk;
    logic               rst;
    logic               spiMode, regWrite, regRead, regRdValid, convDone, resultUpdate;
    sof_byte_t          regAddr, regWrData, regRdData;
    sof_res_t           adcTemp, adcPress, tempResult, pressResult, stT, stP;
    sof_hum_t           adcHum, humResult;
    sof_cnt_t           tempSamples, pressSamples, humSamples;
    sof_coef_t          filterCoef;
    int                 badCount = 0;
    int                 nTests = 0;
    sof_filter_ctrl #(.IDENTITY_CODE(ID)) dut (.clk(clk), .rst(rst), .spiMode(spiMode),
        .regWrite(regWrite), .regRead(regRead), .regAddr(regAddr), .regWrData(regWrData),
        .regRdData(regRdData), .regRdValid(regRdValid), .convDone(convDone),
        .adcTemp(adcTemp), .adcPress(adcPress), .adcHum(adcHum), .tempResult(tempResult),
        .pressResult(pressResult), .humResult(humResult), .resultUpdate(resultUpdate),
        .tempSamples(tempSamples), .pressSamples(pressSamples), .humSamples(humSamples),
        .filterCoef(filterCoef));
    sof_host_model host (.clk(clk), .spiMode(spiMode), .regWrite(regWrite),
        .regRead(regRead), .regAddr(regAddr), .regWrData(regWrData), .regRdData(regRdData),
        .regRdValid(regRdValid), .convDone(convDone), .adcTemp(adcTemp),
        .adcPress(adcPress), .adcHum(adcHum));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [19:0] got, input logic [19:0] exp, input string m);
        nTests++;
        if (got !== exp) begin
            $display("FAIL %0t %s got %h exp %h", $time, m, got, exp);
            badCount++;
        end
    endtask
    // Truncating step, wide enough for state * 127 without overflow
    function automatic sof_res_t iir(input sof_res_t o, input sof_res_t s, input int k);
        logic [27:0] acc;
        acc = {8'h00, o} * ((28'h1 << k) - 28'h1) + {8'h00, s};
        return sof_res_t'(acc >> k);
    endfunction
    function automatic logic [19:0] cnt(input int k);
        return (k == 0) ? 20'h0 : (k >= 5) ? 20'h10 : (20'h1 << (k - 1));
    endfunction
    task automatic meas(input sof_res_t t, input sof_res_t p, input sof_hum_t h,
                        input sof_res_t eT, input sof_res_t eP, input sof_hum_t eH);
        host.measure(t, p, h);
        chk(20'(resultUpdate), 20'h1, "update pulse");
        chk(tempResult, eT, "temp result");
        chk(pressResult, eP, "press result");
        chk(20'(humResult), 20'(eH), "hum result");
        @(posedge clk);
        #1 chk(20'(resultUpdate), 20'h0, "update width");
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task automatic testFilter();
        host.writeReg(`SOF_ADDR_HUM_CTRL, 8'h01);
        host.writeReg(`SOF_ADDR_MEAS_CTRL, 8'h24);
        host.writeReg(`SOF_ADDR_FILT_CFG, 8'h08);
        {stT, stP} = {20'hfffff, 20'h12345};
        meas(stT, stP, 16'habcd, stT, stP, 16'habcd);
        {stT, stP} = {iir(stT, 20'h00010, 2), iir(stP, 20'h80001, 2)};
        meas(20'h00010, 20'h80001, 16'h1234, stT, stP, 16'h1234);
    endtask
    task automatic testSkip();
        host.writeReg(`SOF_ADDR_FILT_CFG, 8'h1c);
        host.writeReg(`SOF_ADDR_HUM_CTRL, 8'h00);
        host.writeReg(`SOF_ADDR_MEAS_CTRL, 8'h14);
        stP = iir(stP, 20'h00000, 7);
        meas(20'h54321, 20'h00000, 16'h7777, `SOF_SKIP_TP, stP, `SOF_SKIP_HUM);
        host.writeReg(`SOF_ADDR_MEAS_CTRL, 8'hb4);
        host.writeReg(`SOF_ADDR_HUM_CTRL, 8'h05);
        {stT, stP} = {iir(stT, 20'h54321, 7), iir(stP, 20'h0ffff, 7)};
        meas(20'h54321, 20'h0ffff, 16'h0001, stT, stP, 16'h0001);
    endtask
    task automatic testPassThrough();
        host.writeReg(`SOF_ADDR_FILT_CFG, 8'h00);
        host.writeReg(`SOF_ADDR_MEAS_CTRL, 8'h80);
        meas(20'h00abc, 20'h11111, 16'h2222, 20'h00abc, `SOF_SKIP_TP, 16'h2222);
    endtask
    task automatic testOversampling();
        sof_byte_t d;
        logic      v;
        for (int k = 0; k < 8; k++) begin
            host.writeReg(`SOF_ADDR_HUM_CTRL, 8'(k));
            host.writeReg(`SOF_ADDR_MEAS_CTRL, {3'(k), 3'(7 - k), 2'b00});
            host.writeReg(`SOF_ADDR_FILT_CFG, {3'h0, 3'(k), 2'b00});
            host.readReg(`SOF_ADDR_MEAS_CTRL, d, v);
            chk(20'({v, d}), 20'({1'b1, 3'(k), 3'(7 - k), 2'b00}), "meas readback");
            chk(20'(humSamples), cnt(k), "hum count");
            chk(20'(tempSamples), cnt(k), "temp count");
            chk(20'(pressSamples), cnt(7 - k), "press count");
            chk(20'(filterCoef), (20'h1 << k) - 20'h1, "coefficient");
        end
    endtask
    task automatic testIdentity();
        sof_byte_t d;
        logic      v;
        host.writeReg(`SOF_ADDR_ID, ~ID);
        host.readReg(`SOF_ADDR_ID, d, v);
        chk(20'({v, d}), 20'({1'b1, ID}), "id read");
        host.readReg(8'h99, d, v);
        chk(20'({v, d}), 20'h100, "unmapped read");
        host.setMode(1'b1);
        host.readReg(8'h50, d, v);
        chk(20'({v, d}), 20'({1'b1, ID}), "id page 0");
        host.selectPage(1'b1);
        host.readReg(8'h73, d, v);
        chk(20'({v, d}), 20'h110, "page bit");
        host.readReg(8'h75, d, v);
        chk(20'({v, d}), 20'h11c, "page 1 control");
        host.selectPage(1'b0);
        host.setMode(1'b0);
    endtask
    task automatic testSoftReset();
        sof_byte_t d;
        logic      v;
        host.writeReg(`SOF_ADDR_RESET, `SOF_SOFT_RESET_KEY);
        host.readReg(`SOF_ADDR_FILT_CFG, d, v);
        chk(20'({v, d}), 20'h100, "soft reset control");
        chk(tempResult, `SOF_SKIP_TP, "soft reset temp");
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task automatic summarize();
        if (badCount == 0 && nTests > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    // Whole run is under 150 cycles; this is a generous margin
    initial begin
        #200000;
        badCount++;
        summarize();
    end
    initial begin
        rst = 1'b1;
        repeat (16) @(posedge clk);
        #1 rst = 1'b0;
        testFilter();
        testSkip();
        testPassThrough();
        testOversampling();
        testIdentity();
        testSoftReset();
        summarize();
    end
endmodule

// ==== hdl/sof_defs.svh ====
// Purpose : Constants for the oversampling and IIR filter control block
// Assumes : Included by the bench and by every design file that needs a number
// Notes   : Full addresses are the I2C view; SPI addresses are mapped onto them
`ifndef SOF_DEFS_SVH
`define SOF_DEFS_SVH

`define SOF_ADDR_HUM_CTRL   8'h72
`define SOF_ADDR_STATUS     8'h73
`define SOF_ADDR_MEAS_CTRL  8'h74
`define SOF_ADDR_FILT_CFG   8'h75
`define SOF_ADDR_ID         8'hd0
`define SOF_ADDR_RESET      8'he0
`define SOF_SOFT_RESET_KEY  8'hb6
`define SOF_CTRL_RESET      8'h00
`define SOF_RD_UNMAPPED     8'h00

`define SOF_OSRS_H_MSB      2
`define SOF_OSRS_H_LSB      0
`define SOF_OSRS_T_MSB      7
`define SOF_OSRS_T_LSB      5
`define SOF_OSRS_P_MSB      4
`define SOF_OSRS_P_LSB      2
`define SOF_FILTER_MSB      4
`define SOF_FILTER_LSB      2
`define SOF_PAGE_BIT        4

`define SOF_OSRS_SKIP       3'h0
`define SOF_OSRS_MAX16      3'h5
`define SOF_SAMPLES_16      5'h10
`define SOF_SKIP_TP         20'h80000
`define SOF_SKIP_HUM        16'h8000
`define SOF_SPI_LOW_MASK    7'h7f

`endif

// ==== hdl/sof_filter_ctrl.sv ====
// Purpose : Control registers, oversampling decode and filtered result update
// Assumes : Host register port and converter are logic on the same clock
// Notes   : Results change only on the cycle after convDone or a soft reset, all channels at once
`timescale 1ns/100ps
`include "sof_defs.svh"
module sof_filter_ctrl #(
    parameter logic [7:0] IDENTITY_CODE = 8'h5a // Arbitrary value
) (
    input  wire logic                clk,
    input  wire logic                rst,
    input  wire logic                spiMode,
    input  wire logic                regWrite,
    input  wire logic                regRead,
    input  wire sof_pkg::sof_byte_t  regAddr,
    input  wire sof_pkg::sof_byte_t  regWrData,
    output sof_pkg::sof_byte_t       regRdData,
    output logic                     regRdValid,
    input  wire logic                convDone,
    input  wire sof_pkg::sof_res_t   adcTemp,
    input  wire sof_pkg::sof_res_t   adcPress,
    input  wire sof_pkg::sof_hum_t   adcHum,
    output sof_pkg::sof_res_t        tempResult,
    output sof_pkg::sof_res_t        pressResult,
    output sof_pkg::sof_hum_t        humResult,
    output logic                     resultUpdate,
    output sof_pkg::sof_cnt_t        tempSamples,
    output sof_pkg::sof_cnt_t        pressSamples,
    output sof_pkg::sof_cnt_t        humSamples,
    output sof_pkg::sof_coef_t       filterCoef
);
    import sof_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Decode helpers

    // SPI page folds the 7-bit address
    function automatic sof_byte_t fullAddr(input logic spi, input logic page,
                                           input sof_byte_t addr);
        if (!spi) begin
            fullAddr = addr;
        end else if (addr[6:0] == (`SOF_ADDR_STATUS & `SOF_SPI_LOW_MASK)) begin
            fullAddr = `SOF_ADDR_STATUS;
        end else begin
            fullAddr = {~page, addr[6:0]};
        end
    endfunction

    // skip, 1, 2, 4, 8, then 16
    function automatic sof_cnt_t samplesOf(input sof_osr_t code);
        if (code == `SOF_OSRS_SKIP) begin
            samplesOf = 5'h00;
        end else if (code >= `SOF_OSRS_MAX16) begin
            samplesOf = `SOF_SAMPLES_16;
        end else begin
            samplesOf = 5'(5'h01 << (code - 3'h1));
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // State

    sof_byte_t humCtrl,      next_humCtrl;
    sof_byte_t measCtrl,     next_measCtrl;
    sof_byte_t filtCfg,      next_filtCfg;
    logic      memPage,      next_memPage;
    sof_res_t  tempState,    next_tempState;
    sof_res_t  pressState,   next_pressState;
    logic      tempPrimed,   next_tempPrimed;
    logic      pressPrimed,  next_pressPrimed;
    sof_byte_t next_regRdData;
    logic      next_regRdValid;
    sof_res_t  next_tempResult;
    sof_res_t  next_pressResult;
    sof_hum_t  next_humResult;
    logic      next_resultUpdate;
    sof_cnt_t  next_tempSamples;
    sof_cnt_t  next_pressSamples;
    sof_cnt_t  next_humSamples;
    sof_coef_t next_filterCoef;

    sof_byte_t addr;
    sof_osr_t  codeT;
    sof_osr_t  codeP;
    sof_osr_t  codeH;
    sof_osr_t  codeF;
    sof_res_t  tempFiltered;
    sof_res_t  pressFiltered;
    logic      softReset;

    assign addr  = fullAddr(spiMode, memPage, regAddr);
    assign codeT = measCtrl[`SOF_OSRS_T_MSB:`SOF_OSRS_T_LSB];
    assign codeP = measCtrl[`SOF_OSRS_P_MSB:`SOF_OSRS_P_LSB];
    assign codeH = humCtrl[`SOF_OSRS_H_MSB:`SOF_OSRS_H_LSB];
    assign codeF = filtCfg[`SOF_FILTER_MSB:`SOF_FILTER_LSB];
    assign softReset = regWrite && addr == `SOF_ADDR_RESET && regWrData == `SOF_SOFT_RESET_KEY;

    // both filtered channels share one step design
    sof_iir_step uTempStep (
        .prior  (tempState),
        .sample (adcTemp),
        .shift  (codeF),
        .result (tempFiltered)
    );
    sof_iir_step uPressStep (
        .prior  (pressState),
        .sample (adcPress),
        .shift  (codeF),
        .result (pressFiltered)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Next values

    always_comb begin
        next_humCtrl      = humCtrl;
        next_measCtrl     = measCtrl;
        next_filtCfg      = filtCfg;
        next_memPage      = memPage;
        next_tempState    = tempState;
        next_pressState   = pressState;
        next_tempPrimed   = tempPrimed;
        next_pressPrimed  = pressPrimed;
        next_tempResult   = tempResult;
        next_pressResult  = pressResult;
        next_humResult    = humResult;
        next_resultUpdate = convDone;
        next_regRdValid   = regRead;
        next_regRdData    = regRdData;
        next_tempSamples  = samplesOf(codeT);
        next_pressSamples = samplesOf(codeP);
        next_humSamples   = samplesOf(codeH);
        next_filterCoef   = 7'((8'h01 << codeF) - 8'h01);

        if (regRead) begin
            unique case (addr)
                `SOF_ADDR_ID:        next_regRdData = IDENTITY_CODE;
                `SOF_ADDR_HUM_CTRL:  next_regRdData = humCtrl;
                `SOF_ADDR_MEAS_CTRL: next_regRdData = measCtrl;
                `SOF_ADDR_FILT_CFG:  next_regRdData = filtCfg;
                `SOF_ADDR_STATUS:    next_regRdData = 8'(memPage) << `SOF_PAGE_BIT;
                default:             next_regRdData = `SOF_RD_UNMAPPED;
            endcase
        end

        // Measurement uses the settings before any same-cycle write
        if (convDone) begin
            if (codeT == `SOF_OSRS_SKIP) begin
                next_tempResult = `SOF_SKIP_TP;
            end else begin
                next_tempState  = tempPrimed ? tempFiltered : adcTemp;
                next_tempResult = next_tempState;
                next_tempPrimed = 1'b1;
            end
            if (codeP == `SOF_OSRS_SKIP) begin
                next_pressResult = `SOF_SKIP_TP;
            end else begin
                next_pressState  = pressPrimed ? pressFiltered : adcPress;
                next_pressResult = next_pressState;
                next_pressPrimed = 1'b1;
            end
            next_humResult = codeH == `SOF_OSRS_SKIP ? `SOF_SKIP_HUM : adcHum;
        end

        if (regWrite) begin
            unique case (addr)
                `SOF_ADDR_HUM_CTRL:  next_humCtrl  = regWrData;
                `SOF_ADDR_MEAS_CTRL: next_measCtrl = regWrData;
                `SOF_ADDR_FILT_CFG:  next_filtCfg  = regWrData;
                `SOF_ADDR_STATUS:    next_memPage  = regWrData[`SOF_PAGE_BIT];
                default:             next_humCtrl  = humCtrl;
            endcase
        end

        // Soft reset has the same effect as the reset pin on control, filter state and results only
        if (softReset) begin
            next_humCtrl     = `SOF_CTRL_RESET;
            next_measCtrl    = `SOF_CTRL_RESET;
            next_filtCfg     = `SOF_CTRL_RESET;
            next_memPage     = 1'b0;
            next_tempState   = `SOF_SKIP_TP;
            next_pressState  = `SOF_SKIP_TP;
            next_tempPrimed  = 1'b0;
            next_pressPrimed = 1'b0;
            next_tempResult  = `SOF_SKIP_TP;
            next_pressResult = `SOF_SKIP_TP;
            next_humResult   = `SOF_SKIP_HUM;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Registers

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            humCtrl      <= `SOF_CTRL_RESET;
            measCtrl     <= `SOF_CTRL_RESET;
            filtCfg      <= `SOF_CTRL_RESET;
            memPage      <= 1'b0;
            tempState    <= `SOF_SKIP_TP;
            pressState   <= `SOF_SKIP_TP;
            tempPrimed   <= 1'b0;
            pressPrimed  <= 1'b0;
            regRdData    <= `SOF_RD_UNMAPPED;
            regRdValid   <= 1'b0;
            tempResult   <= `SOF_SKIP_TP;
            pressResult  <= `SOF_SKIP_TP;
            humResult    <= `SOF_SKIP_HUM;
            resultUpdate <= 1'b0;
            tempSamples  <= 5'h00;
            pressSamples <= 5'h00;
            humSamples   <= 5'h00;
            filterCoef   <= 7'h00;
        end else begin
            humCtrl      <= next_humCtrl;
            measCtrl     <= next_measCtrl;
            filtCfg      <= next_filtCfg;
            memPage      <= next_memPage;
            tempState    <= next_tempState;
            pressState   <= next_pressState;
            tempPrimed   <= next_tempPrimed;
            pressPrimed  <= next_pressPrimed;
            regRdData    <= next_regRdData;
            regRdValid   <= next_regRdValid;
            tempResult   <= next_tempResult;
            pressResult  <= next_pressResult;
            humResult    <= next_humResult;
            resultUpdate <= next_resultUpdate;
            tempSamples  <= next_tempSamples;
            pressSamples <= next_pressSamples;
            humSamples   <= next_humSamples;
            filterCoef   <= next_filterCoef;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking @(posedge clk); endclocking
    default disable iff (rst);

    sequence tempSkipDone;
        convDone && codeT == `SOF_OSRS_SKIP && !softReset;
    endsequence
    sequence pressSkipDone;
        convDone && codeP == `SOF_OSRS_SKIP && !softReset;
    endsequence

    id_read_value_a: assert property (regRead && addr == `SOF_ADDR_ID |=>
        regRdValid && regRdData == IDENTITY_CODE) else $error("identity read wrong");
    hum_samples_map_a: assert property (codeH >= `SOF_OSRS_MAX16 |=>
        humSamples == `SOF_SAMPLES_16) else $error("humidity count not 16");
    temp_samples_map_a: assert property (codeT == 3'h3 |=>
        tempSamples == 5'h04) else $error("temperature count wrong");
    press_skip_zero_a: assert property (codeP == `SOF_OSRS_SKIP |=>
        pressSamples == 5'h00) else $error("pressure count not zero on skip");
    hum_skip_code_a: assert property (convDone && codeH == `SOF_OSRS_SKIP && !softReset |=>
        humResult == `SOF_SKIP_HUM) else $error("humidity skip value wrong");
    hum_bypass_a: assert property (convDone && codeH != `SOF_OSRS_SKIP && !softReset |=>
        humResult == $past(adcHum)) else $error("humidity not raw");
    results_together_a: assert property ($changed(tempResult) || $changed(pressResult) |->
        $past(convDone) || $past(softReset)) else $error("result changed outside update");
    temp_skip_value_a: assert property (tempSkipDone |=>
        tempResult == `SOF_SKIP_TP) else $error("temperature skip value wrong");
    skip_state_kept_a: assert property (tempSkipDone |=>
        $stable(tempState)) else $error("temperature filter state moved on skip");
    press_state_kept_a: assert property (pressSkipDone |=>
        $stable(pressState)) else $error("pressure filter state moved on skip");
    coef_zero_pass_a: assert property (convDone && codeF == 3'h0 && codeT != 3'h0
        && !softReset |=> tempResult == $past(adcTemp)) else $error("zero coefficient filtered");
    coef_table_a: assert property (codeF == 3'h7 |=>
        filterCoef == 7'h7f) else $error("coefficient 127 wrong");
    after_skip_filtered_a: assert property (convDone && codeT != `SOF_OSRS_SKIP
        && tempPrimed && !softReset |=> 28'(tempResult) == ((28'($past(tempState)) *
        ((28'h1 << $past(codeF)) - 28'h1) + 28'($past(adcTemp))) >> $past(codeF)))
        else $error("first result after skip not filtered");
endmodule

// ==== hdl/sof_iir_step.sv ====
// Purpose : One update step of the first-order IIR filter
// Assumes : Coefficient plus one is a power of two given by its code
// Notes   : Pure combinational; the result truncates toward zero
`timescale 1ns/100ps
module sof_iir_step (
    input  wire logic             [19:0] prior,
    input  wire logic             [19:0] sample,
    input  wire logic             [2:0]  shift,
    output logic                  [19:0] result
);
    logic [27:0] scaled;
    logic [27:0] sum;

    always_comb begin
        scaled = {8'h00, prior} << shift;
        sum    = scaled - {8'h00, prior} + {8'h00, sample};
        result = 20'(sum >> shift);
    end
endmodule

// ==== hdl/sof_pkg.sv ====
// Purpose : Shared types for the oversampling and IIR filter control block
// Assumes : Nothing beyond the constants header
// Notes   : Types only, numbers live in the header
package sof_pkg;
    typedef logic [19:0] sof_res_t;
    typedef logic [15:0] sof_hum_t;
    typedef logic [2:0]  sof_osr_t;
    typedef logic [4:0]  sof_cnt_t;
    typedef logic [6:0]  sof_coef_t;
    typedef logic [7:0]  sof_byte_t;
endpackage
